// [design/qlhbp_defines.svh]
// constants of the quad line interface host bus port
`ifndef QLHBP_DEFINES_SVH
`define QLHBP_DEFINES_SVH
`define QLHBP_NCH        4
`define QLHBP_DW         8
`define QLHBP_AW         5
`define QLHBP_NREG       32
`define QLHBP_CTRL_RST   8'h00
`define QLHBP_STAT_ADDR  5'h1F
`define QLHBP_STAT_BIT   0
`define QLHBP_STROBE_CYC 6
`endif

// [design/qlhbp_device.sv]
// device end: pin sampling, strobe decode, per-channel registers, pin floating
`timescale 1ns/1ps
`include "qlhbp_defines.svh"
module qlhbp_device (
  input  wire logic                  clk,              // system clock
  input  wire logic                  resetn,           // async reset, active low
  qlhbp_if.dev                       pins,             // host-facing pins
  input  wire logic [`QLHBP_NCH-1:0] status_event,     // per-channel status events
  output logic      [`QLHBP_NCH-1:0] line_out_en,      // tip/ring driver enable
  output logic      [`QLHBP_DW-1:0]  ctrl_ch0          // channel 0 control byte
);
  localparam int NS = 12 + `QLHBP_DW + `QLHBP_AW;
  // three-stage sampling of every pin; stage 1 feeds only stage 2
  logic [NS-1:0] s1_r, s2_r, s3_r, st_r, s1_nxt, s2_nxt, s3_nxt, st_nxt;
  logic [NS-1:0] raw;
  assign raw = {pins.port_mode_sel, pins.bus_style_select, pins.channel_select_n,
                pins.rd_strobe_n, pins.wr_strobe_n, pins.addr_strobe_alt,
                pins.host_addr_lines, pins.host_data_lines, pins.output_float_ctrl,
                pins.hard_reset_n};
  always_comb begin
    s1_nxt = raw;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    st_nxt = st_r;
    for (int i = 0; i < NS; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        st_nxt[i] = s3_r[i];
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      st_r <= '1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      st_r <= st_nxt;
    end
  end
  qlhbp_pkg::qlhbp_mode_type mode;
  logic                  style_hi, rd_n, wr_n, as, flt, hard_reset_n_n;
  logic [`QLHBP_NCH-1:0] cs_n;
  logic [`QLHBP_AW-1:0]  a_pins;
  logic [`QLHBP_DW-1:0]  d_pins;
  assign mode     = qlhbp_pkg::qlhbp_mode_type'(st_r[NS-1 -: 2]);
  assign style_hi = st_r[NS-3];
  assign cs_n     = st_r[NS-4 -: `QLHBP_NCH];
  assign rd_n     = st_r[NS-8];
  assign wr_n     = st_r[NS-9];
  assign as       = st_r[NS-10];
  assign a_pins   = st_r[2+`QLHBP_DW +: `QLHBP_AW];
  assign d_pins   = st_r[2 +: `QLHBP_DW];
  assign flt      = st_r[1];
  assign hard_reset_n_n   = st_r[0];
  logic par, any_cs, strobe, is_read, ras_r, ras_nxt, strobe_r, strobe_nxt;
  logic [`QLHBP_AW-1:0] alat_r, alat_nxt, addr;
  assign par    = (mode == qlhbp_pkg::QLHBP_MUX) || (mode == qlhbp_pkg::QLHBP_NONMUX);
  assign any_cs = ~&cs_n;
  // alternate style: one data strobe, write pin becomes read/not-write
  assign strobe  = par && any_cs && (style_hi ? !rd_n : (!rd_n || !wr_n));
  assign is_read = style_hi ? wr_n : !rd_n;
  assign addr    = (mode == qlhbp_pkg::QLHBP_MUX) ? alat_r : a_pins;
  always_comb begin
    ras_nxt    = as;
    strobe_nxt = strobe;
    alat_nxt   = alat_r;
    if (mode == qlhbp_pkg::QLHBP_MUX && as && !ras_r) begin
      alat_nxt = d_pins[`QLHBP_AW-1:0];
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ras_r    <= 1'b0;
      strobe_r <= 1'b0;
      alat_r   <= '0;
    end else begin
      ras_r    <= ras_nxt;
      strobe_r <= strobe_nxt;
      alat_r   <= alat_nxt;
    end
  end
  // per-channel register files; write lands at end of strobe
  logic [`QLHBP_DW-1:0] regs_r [`QLHBP_NCH][`QLHBP_NREG];
  logic [`QLHBP_DW-1:0] regs_nxt [`QLHBP_NCH][`QLHBP_NREG];
  logic [`QLHBP_NCH-1:0] stat_r, stat_nxt;
  logic wr_end, rd_end;
  logic [`QLHBP_NCH-1:0] cs_q_r, cs_q_nxt;
  logic wdir_r, wdir_nxt;
  assign wr_end = strobe_r && !strobe && !wdir_r;
  assign rd_end = strobe_r && !strobe && wdir_r;
  always_comb begin
    regs_nxt = regs_r;
    stat_nxt = stat_r;
    cs_q_nxt = strobe ? ~cs_n : cs_q_r;
    wdir_nxt = strobe ? is_read : wdir_r;
    for (int c = 0; c < `QLHBP_NCH; c++) begin
      if (wr_end && cs_q_r[c]) begin
        regs_nxt[c][addr] = d_pins;
      end
      if (rd_end && cs_q_r[c] && addr == `QLHBP_STAT_ADDR) begin
        stat_nxt[c] = 1'b0;
      end
      if (status_event[c]) begin
        stat_nxt[c] = 1'b1;   // set wins over read clear
      end
    end
    if (!hard_reset_n_n) begin
      for (int c = 0; c < `QLHBP_NCH; c++) begin
        for (int r = 0; r < `QLHBP_NREG; r++) begin
          regs_nxt[c][r] = `QLHBP_CTRL_RST;
        end
      end
      stat_nxt = '0;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < `QLHBP_NCH; c++) begin
        for (int r = 0; r < `QLHBP_NREG; r++) begin
          regs_r[c][r] <= `QLHBP_CTRL_RST;
        end
      end
      stat_r <= '0;
      cs_q_r <= '0;
      wdir_r <= 1'b0;
    end else begin
      regs_r <= regs_nxt;
      stat_r <= stat_nxt;
      cs_q_r <= cs_q_nxt;
      wdir_r <= wdir_nxt;
    end
  end
  // read data and output drivers, all registered
  logic [`QLHBP_DW-1:0] rdata_r, rdata_nxt, oe_r, oe_nxt;
  logic irq_r, irq_nxt;
  logic [`QLHBP_NCH-1:0] lo_r, lo_nxt;
  always_comb begin
    rdata_nxt = '0;
    for (int c = 0; c < `QLHBP_NCH; c++) begin
      if (!cs_n[c]) begin
        rdata_nxt = rdata_nxt | ((addr == `QLHBP_STAT_ADDR) ?
                    {{(`QLHBP_DW-1){1'b0}}, stat_r[c]} : regs_r[c][addr]);
      end
    end
    oe_nxt  = (strobe && is_read && !flt) ? '1 : '0;
    irq_nxt = (|stat_r) && !(flt && any_cs);
    lo_nxt  = flt ? '0 : '1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
      oe_r    <= '0;
      irq_r   <= 1'b0;
      lo_r    <= '0;
    end else begin
      rdata_r <= rdata_nxt;
      oe_r    <= oe_nxt;
      irq_r   <= irq_nxt;
      lo_r    <= lo_nxt;
    end
  end
  assign pins.dev_data_o  = rdata_r;
  assign pins.dev_data_oe = oe_r;
  assign pins.irq_oe      = irq_r;
  assign line_out_en      = lo_r;
  assign ctrl_ch0         = regs_r[0][0];
endmodule : qlhbp_device

// [design/qlhbp_host.sv]
// host end: sequences one parallel access on the pins
`timescale 1ns/1ps
`include "qlhbp_defines.svh"
module qlhbp_host (
  input  wire logic                  clk,          // system clock
  input  wire logic                  resetn,       // async reset, active low
  qlhbp_if.host                      pins,         // device pins
  input  wire logic [1:0]            mode_cfg,     // port mode to strap
  input  wire logic                  style_cfg,    // bus style to strap
  input  wire logic                  float_cfg,    // output float control level
  input  wire logic                  hard_rst_req, // hold device in hard reset
  input  wire logic                  req_valid,    // access request
  output logic                       req_ready,    // request accepted
  input  wire logic                  req_write,    // 1 write, 0 read
  input  wire logic [1:0]            req_chan,     // channel 0..3
  input  wire logic [`QLHBP_AW-1:0]  req_addr,     // register address
  input  wire logic [`QLHBP_DW-1:0]  req_wdata,    // write data
  output logic                       rsp_valid,    // access done pulse
  output logic      [`QLHBP_DW-1:0]  rsp_rdata,    // read data
  output logic                       irq_seen      // interrupt line low
);
  qlhbp_pkg::qlhbp_hst_type st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic w_r, w_nxt, v_r, v_nxt;
  logic [1:0] ch_r, ch_nxt;
  logic [`QLHBP_AW-1:0] a_r, a_nxt;
  logic [`QLHBP_DW-1:0] d_r, d_nxt, rd_r, rd_nxt;
  logic mux;
  assign mux = (mode_cfg == 2'b00);
  assign req_ready = (st_r == qlhbp_pkg::QLHBP_IDLE) && !hard_rst_req;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    w_nxt = w_r;
    ch_nxt = ch_r;
    a_nxt = a_r;
    d_nxt = d_r;
    rd_nxt = rd_r;
    v_nxt = 1'b0;
    cnt_nxt = (cnt_r == 3'h0) ? 3'h0 : cnt_r - 3'h1;
    unique case (st_r)
      qlhbp_pkg::QLHBP_IDLE: begin
        if (req_valid && req_ready) begin
          w_nxt = req_write;
          ch_nxt = req_chan;
          a_nxt = req_addr;
          d_nxt = req_wdata;
          cnt_nxt = 3'(`QLHBP_STROBE_CYC);
          st_nxt = mux ? qlhbp_pkg::QLHBP_ALE : qlhbp_pkg::QLHBP_SETUP;
        end
      end
      qlhbp_pkg::QLHBP_ALE:   if (cnt_r == 3'h0) begin
        cnt_nxt = 3'(`QLHBP_STROBE_CYC);
        st_nxt = qlhbp_pkg::QLHBP_SETUP;
      end
      qlhbp_pkg::QLHBP_SETUP: if (cnt_r == 3'h0) begin
        cnt_nxt = 3'(`QLHBP_STROBE_CYC);
        st_nxt = qlhbp_pkg::QLHBP_STRB;
      end
      qlhbp_pkg::QLHBP_STRB:  if (cnt_r == 3'h0) begin
        rd_nxt = pins.host_data_lines;
        cnt_nxt = 3'(`QLHBP_STROBE_CYC);
        st_nxt = qlhbp_pkg::QLHBP_HOLD;
      end
      qlhbp_pkg::QLHBP_HOLD:  if (cnt_r == 3'h0) begin
        v_nxt = 1'b1;
        st_nxt = qlhbp_pkg::QLHBP_IDLE;
      end
      default: st_nxt = qlhbp_pkg::QLHBP_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= qlhbp_pkg::QLHBP_IDLE;
      cnt_r <= 3'h0;
      w_r <= 1'b0;
      ch_r <= 2'h0;
      a_r <= '0;
      d_r <= '0;
      rd_r <= '0;
      v_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      w_r <= w_nxt;
      ch_r <= ch_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
      rd_r <= rd_nxt;
      v_r <= v_nxt;
    end
  end
  logic act, str;
  assign act = (st_r != qlhbp_pkg::QLHBP_IDLE);
  assign str = (st_r == qlhbp_pkg::QLHBP_STRB);
  assign pins.port_mode_sel     = mode_cfg;
  assign pins.bus_style_select  = style_cfg;
  assign pins.output_float_ctrl = float_cfg;
  assign pins.hard_reset_n      = !hard_rst_req;
  for (genvar c = 0; c < `QLHBP_NCH; c++) begin : g_cs
    assign pins.channel_select_n[c] = !(act && ch_r == 2'(c));
  end
  assign pins.addr_strobe_alt = mux && (st_r == qlhbp_pkg::QLHBP_ALE);
  assign pins.host_addr_lines = mux ? '0 : a_r;
  assign pins.rd_strobe_n = style_cfg ? !str : !(str && !w_r);
  assign pins.wr_strobe_n = style_cfg ? !w_r : !(str && w_r);
  assign pins.host_data_o = (st_r == qlhbp_pkg::QLHBP_ALE) ?
                            {{(`QLHBP_DW-`QLHBP_AW){1'b0}}, a_r} : d_r;
  assign pins.host_data_oe = ((st_r == qlhbp_pkg::QLHBP_ALE) || (act && w_r)) ? '1 : '0;
  assign rsp_valid = v_r;
  assign rsp_rdata = rd_r;
  assign irq_seen = !pins.irq_n_line;
endmodule : qlhbp_host

// [design/qlhbp_if.sv]
// pin-level interface between host and device
`timescale 1ns/1ps
`include "qlhbp_defines.svh"
interface qlhbp_if;
  logic [1:0]              port_mode_sel;
  logic                    bus_style_select;
  logic [`QLHBP_NCH-1:0]   channel_select_n;
  logic                    rd_strobe_n;
  logic                    wr_strobe_n;
  logic                    addr_strobe_alt;
  logic [`QLHBP_AW-1:0]    host_addr_lines;
  logic [`QLHBP_DW-1:0]    host_data_o;
  logic [`QLHBP_DW-1:0]    host_data_oe;
  logic [`QLHBP_DW-1:0]    dev_data_o;
  logic [`QLHBP_DW-1:0]    dev_data_oe;
  logic [`QLHBP_DW-1:0]    host_data_lines;
  logic                    irq_oe;
  logic                    irq_n_line;
  logic                    output_float_ctrl;
  logic                    hard_reset_n;
  assign host_data_lines = (host_data_o & host_data_oe) | (dev_data_o & dev_data_oe)
                         | ~(host_data_oe | dev_data_oe);
  assign irq_n_line = ~irq_oe;
  modport dev (input port_mode_sel, bus_style_select, channel_select_n, rd_strobe_n,
               wr_strobe_n, addr_strobe_alt, host_addr_lines, host_data_lines,
               output_float_ctrl, hard_reset_n, output dev_data_o, dev_data_oe, irq_oe);
  modport host (output port_mode_sel, bus_style_select, channel_select_n, rd_strobe_n,
                wr_strobe_n, addr_strobe_alt, host_addr_lines, host_data_o, host_data_oe,
                output_float_ctrl, hard_reset_n, input host_data_lines, irq_n_line);
endinterface : qlhbp_if

// [design/qlhbp_pkg.sv]
// types of the quad line interface host bus port
package qlhbp_pkg;
  typedef enum logic [1:0] {
    QLHBP_MUX    = 2'b00,
    QLHBP_NONMUX = 2'b01,
    QLHBP_SERIAL = 2'b10,
    QLHBP_HWMODE = 2'b11
  } qlhbp_mode_type;
  typedef enum logic [2:0] {
    QLHBP_IDLE  = 3'b000,
    QLHBP_ALE   = 3'b001,
    QLHBP_SETUP = 3'b010,
    QLHBP_STRB  = 3'b011,
    QLHBP_HOLD  = 3'b100
  } qlhbp_hst_type;
endpackage : qlhbp_pkg

// [verif/qlhbp_pins_sva.sv]
// checker of the host bus pins between the host and device ends
`timescale 1ns/1ps
`include "qlhbp_defines.svh"
module qlhbp_pins_sva (
  input wire logic                  clk,               // clock
  input wire logic                  resetn,            // async reset, active low
  input wire logic [1:0]            port_mode_sel,     // mode straps
  input wire logic                  bus_style_select,  // strobe style
  input wire logic [`QLHBP_NCH-1:0] channel_select_n,  // channel selects
  input wire logic                  rd_strobe_n,       // read or data strobe
  input wire logic                  wr_strobe_n,       // write or direction
  input wire logic                  addr_strobe_alt,   // address latch strobe
  input wire logic [`QLHBP_AW-1:0]  host_addr_lines,   // dedicated address
  input wire logic [`QLHBP_DW-1:0]  host_data_oe,      // host data drive
  input wire logic [`QLHBP_DW-1:0]  dev_data_oe,       // device data drive
  input wire logic                  irq_oe,            // interrupt pull
  input wire logic                  output_float_ctrl, // float control
  input wire logic                  hard_reset_n       // hard reset pin
);
  logic       no_rd;
  logic       flt;
  logic [3:0] nord_r, nord_nxt, flt_r, flt_nxt, hard_reset_n_r, hard_reset_n_nxt;
  // pins pass a 3-flop sync, so spans are counted before an output is judged
  always_comb begin
    no_rd = &channel_select_n | rd_strobe_n | (bus_style_select & ~wr_strobe_n)
          | port_mode_sel[1] | output_float_ctrl;
    flt = output_float_ctrl & ~&channel_select_n;
    nord_nxt = no_rd ? nord_r + {3'h0, nord_r != 4'hF} : 4'h0;
    flt_nxt = flt ? flt_r + {3'h0, flt_r != 4'hF} : 4'h0;
    hard_reset_n_nxt = !hard_reset_n ? hard_reset_n_r + {3'h0, hard_reset_n_r != 4'hF} : 4'h0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nord_r <= 4'h0;
      flt_r <= 4'h0;
      hard_reset_n_r <= 4'h0;
    end else begin
      nord_r <= nord_nxt;
      flt_r <= flt_nxt;
      hard_reset_n_r <= hard_reset_n_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  data_idle_a: assert property (
    nord_r >= 4'h8 |-> dev_data_oe == '0) else $error("device drives data outside a read");
  serial_quiet_a: assert property (
    (port_mode_sel[1] && $stable(port_mode_sel))[*6] |-> dev_data_oe == '0)
    else $error("device drives data in serial or hardware mode");
  irq_float_a: assert property (
    flt_r >= 4'h6 |-> !irq_oe && dev_data_oe == '0) else $error("pins not floated");
  hard_reset_n_irq_a: assert property (
    hard_reset_n_r >= 4'h6 |-> !irq_oe) else $error("interrupt held through hard reset");
  mux_addr_low_a: assert property (
    port_mode_sel == 2'b00 && $stable(port_mode_sel) |-> host_addr_lines == '0)
    else $error("address lines not low in mux mode");
  nonmux_ale_a: assert property (
    port_mode_sel == 2'b01 && $stable(port_mode_sel) |-> !addr_strobe_alt)
    else $error("address strobe high in nonmux mode");
  one_select_a: assert property (
    !port_mode_sel[1] && (!rd_strobe_n || (!bus_style_select && !wr_strobe_n))
    |-> $onehot(~channel_select_n)) else $error("strobe without exactly one select");
  no_clash_a: assert property (
    (host_data_oe & dev_data_oe) == '0) else $error("both ends drive the data lines");
  ale_addr_a: assert property (
    port_mode_sel == 2'b00 && $rose(addr_strobe_alt) |-> host_data_oe == '1)
    else $error("address latched from undriven lines");
  strobe_len_a: assert property (
    $fell(rd_strobe_n) |-> ##[1:8] rd_strobe_n) else $error("read strobe stuck low");
  cover property (port_mode_sel == 2'b00 && !rd_strobe_n);
  cover property (dev_data_oe != '0);
  cover property (irq_oe);
  cover property (flt_r >= 4'h6);
endmodule : qlhbp_pins_sva

// [verif/testbench.sv]
// self-checking bench: host end and device end joined by the pin interface
`timescale 1ns/1ps
`include "qlhbp_defines.svh"
module testbench;
  logic        clk = 1'b0, resetn = 1'b0, style_cfg = 1'b0, float_cfg = 1'b0;
  logic        hard_rst_req = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic        req_ready, rsp_valid, irq_seen;
  logic [1:0]  mode_cfg = 2'b00, req_chan = 2'h0, ch;
  logic [3:0]  status_event = 4'h0, line_out_en;
  logic [4:0]  req_addr = 5'h00, a;
  logic [7:0]  req_wdata = 8'h00, ctrl_ch0, rsp_rdata, rd, wd;
  logic [7:0]  shadow [4][32];
  logic [31:0] seed = 32'h3FF0, r;
  int          n_mismatch = 0, compares = 0, cyc = 0;
  qlhbp_if bus ();
  qlhbp_host qlhbp_host_i (.clk, .resetn, .pins(bus.host), .mode_cfg, .style_cfg, .float_cfg,
    .hard_rst_req, .req_valid, .req_ready, .req_write, .req_chan, .req_addr, .req_wdata,
    .rsp_valid, .rsp_rdata, .irq_seen);
  qlhbp_device qlhbp_device_i (.clk, .resetn, .pins(bus.dev), .status_event, .line_out_en,
    .ctrl_ch0);
  qlhbp_pins_sva qlhbp_pins_sva_i (.clk, .resetn, .port_mode_sel(bus.port_mode_sel),
    .bus_style_select(bus.bus_style_select), .channel_select_n(bus.channel_select_n),
    .rd_strobe_n(bus.rd_strobe_n), .wr_strobe_n(bus.wr_strobe_n),
    .addr_strobe_alt(bus.addr_strobe_alt), .host_addr_lines(bus.host_addr_lines),
    .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe), .irq_oe(bus.irq_oe),
    .output_float_ctrl(bus.output_float_ctrl), .hard_reset_n(bus.hard_reset_n));
  always #5 clk = ~clk;
  // 156 accesses of about 23 (dedicated address) to 30 (mux) cycles each
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // nobody drives the shared lines during a read outside parallel mode, so the pull-up shows
  function automatic logic [7:0] expect_rd(logic [1:0] m, logic [1:0] c, logic [4:0] ad);
    return m[1] ? 8'hFF : shadow[c][ad];
  endfunction : expect_rd
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [1:0] c, input logic [4:0] ad,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_chan = c;
    req_addr = ad;
    req_wdata = d;
    // ready is judged before the taking edge, never after it
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1) @(negedge clk);
    q = rsp_rdata;
  endtask : acc
  task automatic set_mode(input logic [1:0] m, input logic s);
    @(negedge clk);
    mode_cfg = m;
    style_cfg = s;
    repeat (10) @(negedge clk);
  endtask : set_mode
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    foreach (shadow[c, k]) shadow[c][k] = 8'h00;
    repeat (12) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
    chk("line_out_en", 8'h0F, {4'h0, line_out_en});
    for (int k = 0; k < 4; k++) begin
      set_mode({1'b0, k[0]}, k[1]);
      for (int i = 0; i < 12; i++) begin
        r = xs();
        ch = r[1:0];
        a = (i == 0) ? 5'h00 : (i == 1) ? 5'h1E : 5'(r[15:8] % 31);
        wd = r[23:16];
        acc(1'b1, ch, a, wd, rd);
        shadow[ch][a] = wd;
        acc(1'b0, ch, a, 8'h00, rd);
        chk("rdata", expect_rd(mode_cfg, ch, a), rd);
        acc(1'b0, ch + 2'h1, a, 8'h00, rd);
        chk("other_chan", expect_rd(mode_cfg, ch + 2'h1, a), rd);
      end
      chk("ctrl_ch0", shadow[0][0], ctrl_ch0);
    end
    for (int k = 2; k < 4; k++) begin
      set_mode(k[1:0], 1'b0);
      acc(1'b1, 2'h0, 5'h00, ~shadow[0][0], rd);
      acc(1'b0, 2'h0, 5'h00, 8'h00, rd);
      chk("serial_rd", expect_rd(mode_cfg, 2'h0, 5'h00), rd);
    end
    set_mode(2'b00, 1'b0);
    acc(1'b0, 2'h0, 5'h00, 8'h00, rd);
    chk("after_serial", shadow[0][0], rd);
    chk("irq_idle", 8'h00, {7'h0, irq_seen});
    @(negedge clk);
    status_event = 4'h4;
    @(negedge clk);
    status_event = 4'h0;
    repeat (10) @(negedge clk);
    chk("irq_set", 8'h01, {7'h0, irq_seen});
    acc(1'b0, 2'h2, 5'h1F, 8'h00, rd);
    chk("status", 8'h01, {7'h0, rd[0]});
    acc(1'b0, 2'h2, 5'h1F, 8'h00, rd);
    chk("status_clr", 8'h00, {7'h0, rd[0]});
    repeat (10) @(negedge clk);
    chk("irq_clr", 8'h00, {7'h0, irq_seen});
    float_cfg = 1'b1;
    repeat (10) @(negedge clk);
    chk("line_float", 8'h00, {4'h0, line_out_en});
    acc(1'b0, 2'h1, a, 8'h00, rd);
    chk("float_rd", 8'hFF, rd);
    @(negedge clk);
    float_cfg = 1'b0;
    repeat (10) @(negedge clk);
    chk("line_back", 8'h0F, {4'h0, line_out_en});
    hard_rst_req = 1'b1;
    repeat (10) @(negedge clk);
    hard_rst_req = 1'b0;
    repeat (10) @(negedge clk);
    chk("ctrl_ch0_hard_reset_n", 8'h00, ctrl_ch0);
    for (int c = 0; c < 4; c++) begin
      acc(1'b0, c[1:0], a, 8'h00, rd);
      chk("hard_reset_n_rd", 8'h00, rd);
    end
    test_done();
  end
endmodule : testbench
